/* design/mams_pkg.sv */
// Constants for the MAC address filter and statistics counter block
package mams_pkg;

    // Register bus
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam logic [7:0]  HASH_HIGH_OFS     = 8'h00;
    localparam logic [7:0]  CTRL_OFS          = 8'h04;
    localparam logic [7:0]  STATION_BASE_OFS  = 8'h08;
    localparam logic [7:0]  STATION_STRIDE    = 8'h08;
    localparam logic [7:0]  STATION_LOW_OFS   = 8'h04;
    localparam logic [7:0]  COUNT_BASE_OFS    = 8'h40;
    localparam logic [7:0]  COUNT_STRIDE      = 8'h04;

    // Control register fields
    localparam int          CTRL_SPEED100_BIT = 0;
    localparam int          CTRL_HALFDUP_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET        = 2'h0;
    localparam logic [31:0] HASH_HIGH_RESET   = 32'h0000_0000;

    // Station address slots
    localparam int          NUM_SLOTS         = 4;
    localparam int          MAC_W             = 48;
    localparam int          SA_HIGH_W         = 16;

    // Frame status
    localparam int          LEN_W             = 12;
    localparam int          COLL_W            = 5;
    localparam int          HASH_IDX_W        = 6;
    localparam logic [11:0] MIN_FRAME         = 12'h040;
    localparam logic [11:0] MIN_MULTI_FRAME   = 12'h03E;
    localparam logic [11:0] MAX_FRAME         = 12'h5EE;
    localparam logic [4:0]  MAX_RETRY_COLL    = 5'h0F;
    localparam logic [4:0]  ABORT_COLL        = 5'h10;

    // Slot time, 512 bits; a longest wait so it rounds down
    localparam int          SLOT_BITS         = 512;
    localparam int          CLK_NS            = 25;
    localparam int          BIT_NS_100        = 10;
    localparam int          BIT_NS_10         = 100;
    localparam int          SLOT_W            = 12;
    localparam logic [11:0] SLOT_CYC_100      = 12'((SLOT_BITS * BIT_NS_100) / CLK_NS);
    localparam logic [11:0] SLOT_CYC_10       = 12'((SLOT_BITS * BIT_NS_10) / CLK_NS);

    // Counter order and widths, register table order
    localparam int          NUM_CNT           = 18;
    localparam int          CNT_TX_OK         = 0;
    localparam int          CNT_SINGLE_COLL   = 1;
    localparam int          CNT_MULTI_COLL    = 2;
    localparam int          CNT_RX_OK         = 3;
    localparam int          CNT_FCS_ERR       = 4;
    localparam int          CNT_ALIGN_ERR     = 5;
    localparam int          CNT_DEFERRED      = 6;
    localparam int          CNT_LATE_COLL     = 7;
    localparam int          CNT_EXCESS_COLL   = 8;
    localparam int          CNT_TX_UNDERRUN   = 9;
    localparam int          CNT_CARRIER_ERR   = 10;
    localparam int          CNT_RX_DISCARD    = 11;
    localparam int          CNT_RX_OVERRUN    = 12;
    localparam int          CNT_SYMBOL_ERR    = 13;
    localparam int          CNT_TOO_LONG      = 14;
    localparam int          CNT_JABBER        = 15;
    localparam int          CNT_RUNT          = 16;
    localparam int          CNT_HEARTBEAT     = 17;
    localparam int          CNT_WIDTH [NUM_CNT] = '{24, 16, 16, 24, 8, 8, 16, 8, 8,
                                                    8, 8, 16, 8, 8, 8, 8, 8, 8};

endpackage

/* design/mams_sat_counter.sv */
// Saturating statistics counter that clears when read
`timescale 1ns/1ps
module mams_sat_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             inc_in,
    input  wire logic             clr_in,
    // Value
    output logic [WIDTH-1:0]      count_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } mams_cnt_state_t;

    mams_cnt_state_t state_q;
    mams_cnt_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (clr_in) begin
            // An event in the read cycle survives as the first new count
            state_d.count = inc_in ? WIDTH'(1) : '0;
        end else if (inc_in && !(&state_q.count)) begin
            state_d.count = state_q.count + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign count_out = state_q.count;

endmodule // mams_sat_counter

/* design/mams_addr_match.sv */
// Destination address recognition against slots and hash filter
`timescale 1ns/1ps
module mams_addr_match (
    // Filter contents
    input  wire logic [63:0]                                       hash_in,
    input  wire logic [mams_pkg::NUM_SLOTS*mams_pkg::MAC_W-1:0]    slots_in,
    // Candidate
    input  wire logic [mams_pkg::MAC_W-1:0]                        dest_in,
    output logic                                                   match_out
);
    import mams_pkg::*;

    logic [NUM_SLOTS-1:0]  slot_hit;
    logic [HASH_IDX_W-1:0] hash_idx;

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
            assign slot_hit[g] = (slots_in[g*MAC_W +: MAC_W] == dest_in);
        end
    endgenerate

    // Index folds the address into six bits by XOR
    always_comb begin
        hash_idx = '0;
        for (int i = 0; i < MAC_W / HASH_IDX_W; i++) begin
            hash_idx = hash_idx ^ dest_in[i*HASH_IDX_W +: HASH_IDX_W];
        end
    end

    assign match_out = (|slot_hit) | hash_in[hash_idx];

endmodule // mams_addr_match

/* design/mams_top.sv */
// Address filter registers and frame statistics counters of the MAC
`timescale 1ns/1ps
module mams_top (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    // Register port
    input  wire logic [mams_pkg::ADDR_W-1:0]   reg_addr_in,
    input  wire logic [mams_pkg::DATA_W-1:0]   reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic [mams_pkg::DATA_W-1:0]        reg_rdata_out,
    // Lower hash bits from the neighbouring register block
    input  wire logic [31:0]                   hash_low_in,
    // Transmit frame status, one pulse per frame end
    input  wire logic                          tx_done_in,
    input  wire logic                          tx_sent_in,
    input  wire logic                          tx_underrun_in,
    input  wire logic                          tx_carrier_lost_in,
    input  wire logic                          tx_deferred_in,
    input  wire logic                          tx_late_coll_in,
    input  wire logic [mams_pkg::COLL_W-1:0]   tx_coll_count_in,
    input  wire logic [mams_pkg::LEN_W-1:0]    tx_length_in,
    // Receive frame status, one pulse per frame end
    input  wire logic                          rx_done_in,
    input  wire logic [mams_pkg::MAC_W-1:0]    rx_dest_in,
    input  wire logic [mams_pkg::LEN_W-1:0]    rx_length_in,
    input  wire logic                          rx_dribble_in,
    input  wire logic                          rx_crc_bad_in,
    input  wire logic                          rx_symbol_err_in,
    input  wire logic                          rx_no_buffer_in,
    input  wire logic                          rx_overrun_in,
    // Media pins
    input  wire logic                          collision_in_pin,
    input  wire logic                          tx_enable_pin,
    // Status
    output logic                               addr_match_out
);
    import mams_pkg::*;

    typedef struct packed {
        logic [31:0]                    hash_high;
        logic [1:0]                     ctrl;
        logic [NUM_SLOTS-1:0][15:0]     sa_high;
        logic [NUM_SLOTS-1:0][31:0]     sa_low;
        logic [DATA_W-1:0]              rdata;
        logic                           match;
        logic [1:0]                     coll_sync;
        logic [1:0]                     txen_sync;
        logic                           txen_prev;
        logic                           sqe_armed;
        logic [SLOT_W-1:0]              sqe_timer;
        logic                           sqe_miss;
    } mams_state_t;

    mams_state_t state_q;
    mams_state_t state_d;

    logic [NUM_CNT-1:0]                   cnt_inc;
    logic [NUM_CNT-1:0]                   cnt_clr;
    logic [NUM_CNT-1:0][DATA_W-1:0]       cnt_val;
    logic [NUM_SLOTS*MAC_W-1:0]           slots_flat;
    logic                                 rx_match;
    logic                                 speed100;
    logic                                 half_duplex;

    assign speed100    = state_q.ctrl[CTRL_SPEED100_BIT];
    assign half_duplex = state_q.ctrl[CTRL_HALFDUP_BIT];

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_flat
            assign slots_flat[g*MAC_W +: MAC_W] = {state_q.sa_high[g], state_q.sa_low[g]};
        end
    endgenerate

    mams_addr_match u_match (
        .hash_in   ({state_q.hash_high, hash_low_in}),
        .slots_in  (slots_flat),
        .dest_in   (rx_dest_in),
        .match_out (rx_match)
    );

    // Transmit classification
    logic tx_uf;
    logic tx_clean;
    logic tx_len_std;
    logic tx_len_multi;
    logic tx_abort;

    assign tx_uf        = tx_done_in & tx_underrun_in;
    assign tx_clean     = tx_done_in & !tx_underrun_in & !tx_carrier_lost_in;
    assign tx_len_std   = (tx_length_in >= MIN_FRAME) && (tx_length_in <= MAX_FRAME);
    assign tx_len_multi = (tx_length_in >= MIN_MULTI_FRAME) && (tx_length_in <= MAX_FRAME);
    assign tx_abort     = (tx_coll_count_in >= ABORT_COLL);

    // Receive classification
    logic rx_rec;
    logic rx_sym;
    logic rx_any;
    logic rx_err;
    logic rx_len_std;
    logic rx_long;
    logic rx_short;

    assign rx_rec     = rx_done_in & rx_match;
    // A recognized frame with a symbol error is counted there alone
    assign rx_sym     = rx_rec & rx_symbol_err_in;
    assign rx_any     = rx_done_in & !rx_sym;
    assign rx_err     = rx_crc_bad_in | rx_symbol_err_in;
    assign rx_len_std = (rx_length_in >= MIN_FRAME) && (rx_length_in <= MAX_FRAME);
    assign rx_long    = (rx_length_in > MAX_FRAME);
    assign rx_short   = (rx_length_in < MIN_FRAME);

    always_comb begin
        cnt_inc = '0;
        // Underrun frames touch only their own counter
        cnt_inc[CNT_TX_UNDERRUN] = tx_uf;
        cnt_inc[CNT_TX_OK]       = tx_done_in & !tx_underrun_in & tx_sent_in;
        cnt_inc[CNT_SINGLE_COLL] = tx_clean & tx_sent_in
                                   & (tx_coll_count_in == COLL_W'(1));
        cnt_inc[CNT_MULTI_COLL]  = tx_clean & tx_sent_in & tx_len_multi
                                   & (tx_coll_count_in > COLL_W'(1))
                                   & (tx_coll_count_in <= MAX_RETRY_COLL);
        cnt_inc[CNT_DEFERRED]    = tx_done_in & !tx_underrun_in & tx_deferred_in
                                   & (tx_coll_count_in == '0);
        // Late collisions also appear in the collision counts above
        cnt_inc[CNT_LATE_COLL]   = tx_clean & tx_late_coll_in;
        cnt_inc[CNT_EXCESS_COLL] = tx_clean & tx_abort & tx_len_std;
        cnt_inc[CNT_CARRIER_ERR] = tx_done_in & !tx_underrun_in & half_duplex
                                   & tx_carrier_lost_in & !tx_abort;
        cnt_inc[CNT_HEARTBEAT]   = state_q.sqe_miss;

        cnt_inc[CNT_SYMBOL_ERR]  = rx_sym;
        cnt_inc[CNT_RX_OK]       = rx_rec & !rx_sym & rx_len_std & !rx_crc_bad_in;
        cnt_inc[CNT_FCS_ERR]     = rx_rec & !rx_sym & rx_len_std
                                   & !rx_dribble_in & rx_crc_bad_in;
        cnt_inc[CNT_ALIGN_ERR]   = rx_rec & !rx_sym & rx_len_std
                                   & rx_dribble_in & rx_crc_bad_in;
        cnt_inc[CNT_RX_DISCARD]  = rx_rec & !rx_sym & rx_no_buffer_in;
        cnt_inc[CNT_RX_OVERRUN]  = rx_rec & !rx_sym & rx_overrun_in;
        cnt_inc[CNT_TOO_LONG]    = rx_any & rx_long & !rx_err;
        cnt_inc[CNT_JABBER]      = rx_any & rx_long & rx_err;
        cnt_inc[CNT_RUNT]        = rx_any & rx_short & !rx_err;
    end

    // Counter bank, one saturating clear-on-read counter per statistic
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            localparam int W = CNT_WIDTH[g];
            logic [W-1:0] value;

            assign cnt_clr[g] = reg_rd_in
                                && (reg_addr_in == 8'(COUNT_BASE_OFS + COUNT_STRIDE * g));

            mams_sat_counter #(
                .WIDTH (W)
            ) u_cnt (
                .clk_in    (clk_in),
                .rst_n_in  (rst_n_in),
                .inc_in    (cnt_inc[g]),
                .clr_in    (cnt_clr[g]),
                .count_out (value)
            );

            assign cnt_val[g] = {{(DATA_W - W){1'b0}}, value};
        end
    endgenerate

    // Register file, heartbeat monitor and read path
    always_comb begin
        logic [ADDR_W-1:0] slot_ofs;
        logic [DATA_W-1:0] rd;
        state_d  = state_q;
        slot_ofs = '0;
        rd       = '0;

        // Pins pass two flops before anything looks at them
        state_d.coll_sync = {state_q.coll_sync[0], collision_in_pin};
        state_d.txen_sync = {state_q.txen_sync[0], tx_enable_pin};
        state_d.txen_prev = state_q.txen_sync[1];
        state_d.sqe_miss  = 1'b0;
        state_d.match     = rx_match;

        // Heartbeat window opens when transmit enable falls
        if (state_q.txen_prev && !state_q.txen_sync[1]) begin
            state_d.sqe_armed = 1'b1;
            state_d.sqe_timer = speed100 ? SLOT_CYC_100 : SLOT_CYC_10;
        end else if (state_q.sqe_armed) begin
            if (state_q.coll_sync[1]) begin
                state_d.sqe_armed = 1'b0;
            end else if (state_q.sqe_timer == '0) begin
                state_d.sqe_armed = 1'b0;
                state_d.sqe_miss  = 1'b1;
            end else begin
                state_d.sqe_timer = state_q.sqe_timer - SLOT_W'(1);
            end
        end

        if (reg_wr_in) begin
            if (reg_addr_in == HASH_HIGH_OFS) begin
                state_d.hash_high = reg_wdata_in;
            end
            if (reg_addr_in == CTRL_OFS) begin
                state_d.ctrl = reg_wdata_in[1:0];
            end
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_ofs = 8'(STATION_BASE_OFS + STATION_STRIDE * i);
                if (reg_addr_in == slot_ofs) begin
                    state_d.sa_high[i] = reg_wdata_in[SA_HIGH_W-1:0];
                end
                if (reg_addr_in == 8'(slot_ofs + STATION_LOW_OFS)) begin
                    state_d.sa_low[i] = reg_wdata_in;
                end
            end
        end

        if (reg_rd_in) begin
            if (reg_addr_in == HASH_HIGH_OFS) begin
                rd = state_q.hash_high;
            end
            if (reg_addr_in == CTRL_OFS) begin
                rd = {30'h0000_0000, state_q.ctrl};
            end
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_ofs = 8'(STATION_BASE_OFS + STATION_STRIDE * i);
                if (reg_addr_in == slot_ofs) begin
                    rd = {16'h0000, state_q.sa_high[i]};
                end
                if (reg_addr_in == 8'(slot_ofs + STATION_LOW_OFS)) begin
                    rd = state_q.sa_low[i];
                end
            end
            for (int i = 0; i < NUM_CNT; i++) begin
                if (cnt_clr[i]) begin
                    rd = cnt_val[i];
                end
            end
        end
        // Read data stands for one cycle only; unmapped reads return zero
        state_d.rdata = rd;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q           <= '0;
            state_q.hash_high <= HASH_HIGH_RESET;
            state_q.ctrl      <= CTRL_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_out  = state_q.rdata;
    assign addr_match_out = state_q.match;

endmodule // mams_top

/* tb/mams_phy_model.sv */
// Transceiver model answering each frame end with a collision test pulse
`timescale 1ns/1ps
module mams_phy_model (
    // Clock and media pins
    input  wire logic clk_in,
    input  wire logic tx_enable_pin,
    // Scenario control
    input  wire logic hb_on_in,
    output logic      collision_in_pin
);
    logic       en_q = 1'h0;
    logic [5:0] cnt_q = 6'h00;
    initial collision_in_pin = 1'h0;
    // Pulse well inside the slot window so synchroniser delay cannot push it out
    always @(posedge clk_in) begin
        en_q <= tx_enable_pin;
        if (en_q && !tx_enable_pin && hb_on_in) cnt_q <= 6'h01;
        else if (cnt_q != 6'h00 && cnt_q < 6'h1C) cnt_q <= cnt_q + 6'h01;
        else cnt_q <= 6'h00;
        collision_in_pin <= (cnt_q >= 6'h14) && (cnt_q < 6'h1C);
    end
endmodule // mams_phy_model

/* tb/mams_chk.sv */
// Concurrent checks on the register port of the statistics block
`timescale 1ns/1ps
module mams_chk (
    // Clock and reset
    input wire logic                         clk_in,
    input wire logic                         rst_n_in,
    // Register port and frame strobes
    input wire logic [mams_pkg::ADDR_W-1:0]  reg_addr_in,
    input wire logic [mams_pkg::DATA_W-1:0]  reg_wdata_in,
    input wire logic                         reg_wr_in,
    input wire logic                         reg_rd_in,
    input wire logic [mams_pkg::DATA_W-1:0]  reg_rdata_out,
    input wire logic                         tx_done_in,
    input wire logic                         rx_done_in
);
    import mams_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    AST_HASH: assert property (
        reg_wr_in && reg_addr_in == HASH_HIGH_OFS ##1 !reg_wr_in ##1 s_rd(HASH_HIGH_OFS)
        |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("hash high readback wrong");
    AST_SA_LO: assert property (
        reg_wr_in && reg_addr_in == 8'h24 ##1 !reg_wr_in ##1 s_rd(8'h24)
        |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("station low readback wrong");
    AST_SA_HI: assert property (s_rd(8'h20) |=> reg_rdata_out[31:16] == 16'h0000)
        else $error("station high upper bits set");
    AST_CLR: assert property (
        (reg_rd_in && reg_addr_in inside {[8'h40:8'h84]} && !tx_done_in && !rx_done_in)
        ##1 (reg_rd_in && $stable(reg_addr_in)) |=> reg_rdata_out == 32'h0) else $error("counter not cleared");
    AST_TXOK_W: assert property (s_rd(8'h40) |=> reg_rdata_out[31:24] == 8'h00)
        else $error("sent count too wide");
    AST_SCOL_W: assert property (s_rd(8'h44) |=> reg_rdata_out[31:16] == 16'h0000)
        else $error("single collision count too wide");
    AST_RXOK_W: assert property (s_rd(8'h4C) |=> reg_rdata_out[31:24] == 8'h00)
        else $error("received count too wide");
    AST_FCS_W: assert property (s_rd(8'h50) |=> reg_rdata_out[31:8] == 24'h00_0000)
        else $error("check sequence count too wide");
    AST_DEF_W: assert property (s_rd(8'h58) |=> reg_rdata_out[31:16] == 16'h0000)
        else $error("deferred count too wide");
    AST_RUNT_W: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == 8'h80 |-> reg_rdata_out[31:8] == 24'h00_0000)
        else $error("short frame count too wide");
    cover property (s_rd(8'h80) ##1 reg_rdata_out == 32'h0000_00FF);
    cover property (reg_wr_in ##2 reg_rd_in);
    cover property (reg_rd_in ##1 reg_rd_in);
endmodule // mams_chk

bind mams_top mams_chk i_chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .tx_done_in, .rx_done_in);

/* tb/test_mams_top.sv */
// Self-checking bench for the address filter and statistics block
`timescale 1ns/1ps
module test_mams_top;
    import mams_pkg::*;
    localparam logic [47:0] SA = 48'h1234_5678_9ABC;
    logic        clk_in = 1'h0, rst_n_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0, hb_on = 1'h0, m_q;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, hash_low_in = 32'h0, reg_rdata_out, rd_q;
    logic        tx_done_in = 1'h0, tx_sent_in = 1'h0, tx_underrun_in = 1'h0, tx_carrier_lost_in = 1'h0;
    logic        tx_deferred_in = 1'h0, tx_late_coll_in = 1'h0, tx_enable_pin = 1'h0, collision_in_pin;
    logic        rx_done_in = 1'h0, rx_dribble_in = 1'h0, rx_crc_bad_in = 1'h0, rx_symbol_err_in = 1'h0;
    logic        rx_no_buffer_in = 1'h0, rx_overrun_in = 1'h0, addr_match_out;
    logic [4:0]  tx_coll_count_in = 5'h00;
    logic [11:0] tx_length_in = 12'h000, rx_length_in = 12'h000;
    logic [47:0] rx_dest_in = 48'h0;
    int          num_errors = 0, checked = 0;
    always #12.5 clk_in = ~clk_in;
    mams_top i_dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .hash_low_in, .tx_done_in, .tx_sent_in, .tx_underrun_in, .tx_carrier_lost_in, .tx_deferred_in,
        .tx_late_coll_in, .tx_coll_count_in, .tx_length_in, .rx_done_in, .rx_dest_in, .rx_length_in,
        .rx_dribble_in, .rx_crc_bad_in, .rx_symbol_err_in, .rx_no_buffer_in, .rx_overrun_in,
        .collision_in_pin, .tx_enable_pin, .addr_match_out);
    mams_phy_model i_phy (.clk_in, .tx_enable_pin, .hb_on_in(hb_on), .collision_in_pin);
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Every task that waits on the clock starts and ends in the time step of a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'h0;
        @(negedge clk_in);
        rd_q = reg_rdata_out;
        @(posedge clk_in);
    endtask
    task automatic cc(input int k, input logic [31:0] e);
        rd(COUNT_BASE_OFS + 8'(4 * k));
        cmp($sformatf("count %0d", k), e, rd_q);
    endtask
    task automatic tx(input logic [4:0] f, input logic [4:0] n, input logic [11:0] len);
        {tx_sent_in, tx_underrun_in, tx_carrier_lost_in, tx_deferred_in, tx_late_coll_in} <= f;
        tx_coll_count_in <= n;
        tx_length_in <= len;
        tx_done_in <= 1'h1;
        @(posedge clk_in);
        tx_done_in <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic rx(input logic [47:0] d, input logic [11:0] len, input logic [4:0] f);
        {rx_dribble_in, rx_crc_bad_in, rx_symbol_err_in, rx_no_buffer_in, rx_overrun_in} <= f;
        rx_dest_in <= d;
        rx_length_in <= len;
        rx_done_in <= 1'h1;
        @(posedge clk_in);
        rx_done_in <= 1'h0;
        @(negedge clk_in);
        m_q = addr_match_out;
        @(posedge clk_in);
    endtask
    task automatic t_regs();
        wr(HASH_HIGH_OFS, 32'hA5A5_5A5A);
        rd(HASH_HIGH_OFS);
        cmp("hash high", 32'hA5A5_5A5A, rd_q);
        wr(8'h20, 32'hFFFF_1234);
        wr(8'h24, 32'h5678_9ABC);
        rd(8'h24);
        cmp("slot 3 low", 32'h5678_9ABC, rd_q);
        rd(8'h20);
        cmp("slot 3 high", 32'h0000_1234, rd_q);
        wr(COUNT_BASE_OFS, 32'h55);
        cc(CNT_TX_OK, 32'h0);
    endtask
    task automatic t_tx();
        wr(CTRL_OFS, 32'h3);
        tx(5'h10, 5'h00, MIN_FRAME);
        cc(CNT_TX_OK, 32'h1);
        tx(5'h10, 5'h01, MIN_FRAME);
        cc(CNT_SINGLE_COLL, 32'h1);
        tx(5'h10, MAX_RETRY_COLL, MAX_FRAME);
        cc(CNT_MULTI_COLL, 32'h1);
        tx(5'h00, ABORT_COLL, MIN_FRAME);
        cc(CNT_EXCESS_COLL, 32'h1);
        tx(5'h12, 5'h00, MIN_FRAME);
        cc(CNT_DEFERRED, 32'h1);
        tx(5'h11, 5'h01, MIN_FRAME);
        cc(CNT_LATE_COLL, 32'h1);
        cc(CNT_SINGLE_COLL, 32'h1);
        tx(5'h14, 5'h00, MIN_FRAME);
        cc(CNT_CARRIER_ERR, 32'h1);
        for (int k = 0; k < NUM_CNT; k++) rd(COUNT_BASE_OFS + 8'(4 * k));
        tx(5'h1A, 5'h01, MIN_FRAME);
        for (int k = 0; k < NUM_CNT; k++) cc(k, 32'(k == CNT_TX_UNDERRUN));
        wr(CTRL_OFS, 32'h1);
        tx(5'h14, 5'h00, MIN_FRAME);
        cc(CNT_CARRIER_ERR, 32'h0);
    endtask
    task automatic t_rx();
        wr(8'h08, 32'h1234);
        wr(8'h0C, 32'h5678_9ABC);
        wr(HASH_HIGH_OFS, 32'h2);
        rx(SA, MIN_FRAME, 5'h00);
        cmp("slot match", 32'h1, 32'(m_q));
        cc(CNT_RX_OK, 32'h1);
        rx(48'h21, MIN_FRAME, 5'h00);
        cc(CNT_RX_OK, 32'h1);
        rx(48'hAAAA_0000_0000, MIN_FRAME, 5'h00);
        cmp("no match", 32'h0, 32'(m_q));
        cc(CNT_RX_OK, 32'h0);
        hash_low_in <= 32'h0000_0002;
        rx(48'h01, MIN_FRAME, 5'h00);
        cmp("hash low hit", 32'h1, 32'(m_q));
        rx(SA, MAX_FRAME, 5'h08);
        cc(CNT_FCS_ERR, 32'h1);
        rx(SA, 12'h100, 5'h18);
        cc(CNT_ALIGN_ERR, 32'h1);
        rx(SA, MIN_FRAME, 5'h02);
        cc(CNT_RX_DISCARD, 32'h1);
        rx(SA, MIN_FRAME, 5'h01);
        cc(CNT_RX_OVERRUN, 32'h1);
        rx(SA, 12'h5EF, 5'h00);
        cc(CNT_TOO_LONG, 32'h1);
        rx(SA, 12'h5EF, 5'h08);
        cc(CNT_JABBER, 32'h1);
        rx(SA, 12'h03F, 5'h00);
        cc(CNT_RUNT, 32'h1);
        for (int k = 0; k < NUM_CNT; k++) rd(COUNT_BASE_OFS + 8'(4 * k));
        rx(SA, MIN_FRAME, 5'h0C);
        for (int k = 0; k < NUM_CNT; k++) cc(k, 32'(k == CNT_SYMBOL_ERR));
    endtask
    task automatic t_sat();
        repeat (256) rx(48'hAAAA_0000_0000, 12'h020, 5'h00);
        reg_rd_in <= 1'h1;
        reg_addr_in <= COUNT_BASE_OFS + 8'(4 * CNT_RUNT);
        @(posedge clk_in);
        @(negedge clk_in);
        cmp("runt full", 32'hFF, reg_rdata_out);
        @(posedge clk_in);
        reg_rd_in <= 1'h0;
        @(negedge clk_in);
        cmp("runt reread", 32'h0, reg_rdata_out);
        @(posedge clk_in);
    endtask
    // First pass answers the frame end, second pass stays silent
    task automatic t_hb();
        for (int i = 0; i < 2; i++) begin
            hb_on <= (i == 0);
            tx_enable_pin <= 1'h1;
            repeat (40) @(posedge clk_in);
            tx_enable_pin <= 1'h0;
            repeat (300) @(posedge clk_in);
            cc(CNT_HEARTBEAT, 32'(i));
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        @(posedge clk_in);
        t_regs();
        t_tx();
        t_rx();
        t_sat();
        t_hb();
        end_of_test();
    end
    // About fourteen times the expected run length
    initial begin
        #500000;
        num_errors++;
        end_of_test();
    end
endmodule // test_mams_top
